// *** pkg/wdog_pkg.sv ***
// Package with register map, field positions and reset values of the counter array watchdog
package wdog_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'hd8;
  localparam logic [7:0] MODE_ADDR      = 8'hd9;
  localparam logic [7:0] CNT_LO_ADDR    = 8'he9;
  localparam logic [7:0] CNT_HI_ADDR    = 8'hf9;
  localparam logic [7:0] M4_LO_ADDR     = 8'hee;
  localparam logic [7:0] M4_HI_ADDR     = 8'hfe;
  localparam int CTRL_OVF_BIT   = 7;
  localparam int CTRL_RUN_BIT   = 6;
  localparam int CTRL_M4_BIT    = 4;
  localparam int MODE_IDLE_BIT  = 7;
  localparam int MODE_EN_BIT    = 6;
  localparam int MODE_LOCK_BIT  = 5;
  localparam int MODE_TB_LSB    = 1;
  localparam int MODE_IRQ_BIT   = 0;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] MODE_RESET     = 8'h40;
  localparam logic [7:0] CTRL_WMASK     = 8'hdf;
  localparam logic [7:0] MODE_WMASK     = 8'hef;
  localparam logic [7:0] CNT_RESET      = 8'h00;
  localparam logic [7:0] M4_LO_RESET    = 8'h00;
  localparam logic [2:0] TB_DIV12       = 3'h0;
  localparam logic [2:0] TB_DIV4        = 3'h1;
  localparam logic [2:0] TB_TIMER0      = 3'h2;
  localparam logic [2:0] TB_EXT_FALL    = 3'h3;
  localparam logic [2:0] TB_SYSTEM_CLOCK      = 3'h4;
  localparam logic [2:0] TB_EXT_DIV8    = 3'h5;
  localparam int DIV12_CYCLES   = 12;
  localparam int DIV4_CYCLES    = 4;
  localparam int DIV8_CYCLES    = 8;
endpackage

// *** pkg/tick_if.sv ***
// Interface carrying timebase selection and tick between watchdog core and timebase
`timescale 1ns/1ps
interface tick_if;
  logic [2:0] sel;
  logic       tick;
  modport gen (input sel, output tick);
  modport use_side (output sel, input tick);
endinterface

// *** core/wdog_timebase.sv ***
// Counter timebase generator: one-cycle tick per counter clock
`timescale 1ns/1ps
module wdog_timebase
  import wdog_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic timer0_ovf,
  input  wire logic ext_in,
  tick_if.gen       tb
);
  logic [3:0] div_q;
  logic [3:0] ediv_q;
  logic       ext_q;
  logic       ext_fall;
  logic [3:0] limit;
  logic       div_tick;
  logic       ext8_tick;

  assign ext_fall  = ext_q & ~ext_in;
  assign limit     = (tb.sel == TB_DIV4) ? 4'(DIV4_CYCLES - 1) : 4'(DIV12_CYCLES - 1);
  assign div_tick  = (div_q == limit);
  assign ext8_tick = ext_fall & (ediv_q == 4'(DIV8_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (reset | div_tick) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end

  // External edge divider; falling edges counted, synchronised by assumption
  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_q  <= 1'b0;
      ediv_q <= 4'h0;
    end else begin
      ext_q <= ext_in;
      if (ext_fall) ediv_q <= ext8_tick ? 4'h0 : ediv_q + 4'h1;
    end
  end

  always_comb begin
    case (tb.sel)
      TB_DIV12, TB_DIV4: tb.tick = div_tick;
      TB_TIMER0:         tb.tick = timer0_ovf;
      TB_EXT_FALL:       tb.tick = ext_fall;
      TB_SYSTEM_CLOCK:         tb.tick = 1'b1;
      TB_EXT_DIV8:       tb.tick = ext8_tick;
      default:           tb.tick = 1'b0;
    endcase
  end
endmodule

// *** core/wdog_ctrl.sv ***
// Counter array watchdog: control, mode, counter and module-4 watchdog logic
// Operation
// - Timebase and idle-suspend writes ignored while watchdog enabled.
// - Watchdog enabled when enable or lock bit set.
// - Lock holds watchdog enabled until next reset.
// - Lock clear: writing zero to enable disables watchdog.
// - Enable bit reads one after every reset.
// - Reset: timebase divide-by-twelve, counter low and offset byte zero.
// - Idle-suspend set halts counting while CPU idle.
// - Overflow flag set when 16-bit counter wraps to zero.
// - Enabled overflow flag requests interrupt; only software clears it.
// - Control bit 6 runs counter, forced on by watchdog.
// - Unused bits read zero; writes ignored.
// - Module flags set on match, request interrupt when enabled, cleared by software.
// - Control register bit-addressable; bit operations touch only addressed bit.
// - Mode: idle bit 7, enable bit 6, lock bit 5; only enable resets one.
// - Update-byte write loads counter high byte plus offset byte.
// - Enabled: low byte overflow with high byte match requests reset.
// - Enabled: writing one to module-4 flag forces watchdog reset.
// - Timebase code zero selects system clock divided by twelve.
`timescale 1ns/1ps
module wdog_ctrl
  import wdog_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       bit_wr,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_val,
  input  wire logic       cpu_idle,
  input  wire logic       timer0_ovf,
  input  wire logic       ext_in,
  input  wire logic [3:0] module_match,
  input  wire logic [3:0] module_irq_en,
  input  wire logic       module4_irq_en,
  output logic      [7:0] sfr_rdata,
  output logic            array_irq,
  output logic            watchdog_reset_req,
  output logic            watchdog_active
);
  import wdog_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] cnt_lo_q;
  logic [7:0] cnt_hi_q;
  logic [7:0] m4_lo_q;
  logic [7:0] m4_hi_q;
  logic [7:0] rdata_q;
  logic       irq_q;
  logic       wdrst_q;
  logic       active_q;

  tick_if tb ();

  wdog_timebase u_timebase (
    .mclk       (mclk),
    .reset      (reset),
    .timer0_ovf (timer0_ovf),
    .ext_in     (ext_in),
    .tb         (tb)
  );

  logic       wd_on;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_m4lo;
  logic       wr_m4hi;
  logic       run_eff;
  logic       count_en;
  logic       lo_ovf;
  logic       ovf16;
  logic [7:0] ctrl_wval;
  logic [7:0] ctrl_set;
  logic [7:0] ctrl_d;
  logic [7:0] mode_d;
  logic       force_rst;
  logic       match_rst;
  logic [7:0] rd_mux;

  assign wd_on     = mode_q[MODE_EN_BIT] | mode_q[MODE_LOCK_BIT];
  assign wr_ctrl   = sfr_wr & (sfr_addr == CTRL_ADDR);
  assign wr_mode   = sfr_wr & (sfr_addr == MODE_ADDR);
  assign wr_lo     = sfr_wr & (sfr_addr == CNT_LO_ADDR) & ~wd_on;
  assign wr_hi     = sfr_wr & (sfr_addr == CNT_HI_ADDR) & ~wd_on;
  assign wr_m4lo   = sfr_wr & (sfr_addr == M4_LO_ADDR);
  assign wr_m4hi   = sfr_wr & (sfr_addr == M4_HI_ADDR);
  assign run_eff   = ctrl_q[CTRL_RUN_BIT] | wd_on;
  // Idle suspend gates the timebase, not the run bit
  assign count_en  = run_eff & tb.tick & ~(mode_q[MODE_IDLE_BIT] & cpu_idle);
  assign lo_ovf    = count_en & (cnt_lo_q == 8'hff);
  assign ovf16     = lo_ovf & (cnt_hi_q == 8'hff);
  assign tb.sel    = mode_q[MODE_TB_LSB +: 3];

  // Bit writes build a one-hot replacement so only the addressed bit moves
  always_comb begin
    ctrl_wval = ctrl_q;
    if (wr_ctrl) ctrl_wval = sfr_wdata;
    else if (bit_wr) ctrl_wval[bit_sel] = bit_val;
  end

  assign force_rst = wd_on & ((wr_ctrl & sfr_wdata[CTRL_M4_BIT]) |
                              (bit_wr & ~wr_ctrl & (bit_sel == 3'(CTRL_M4_BIT)) & bit_val));
  assign match_rst = wd_on & lo_ovf & (cnt_hi_q == m4_hi_q);
  // Hardware set wins over software clear
  assign ctrl_set  = {ovf16, 2'b00, match_rst, module_match};
  assign ctrl_d    = (((ctrl_wval & CTRL_WMASK) | ctrl_set)) & CTRL_WMASK;

  always_comb begin
    mode_d = mode_q;
    if (wr_mode) begin
      mode_d[MODE_IRQ_BIT] = sfr_wdata[MODE_IRQ_BIT];
      mode_d[MODE_LOCK_BIT] = mode_q[MODE_LOCK_BIT] | sfr_wdata[MODE_LOCK_BIT];
      // Setting lock also sets enable, so a locked watchdog never reads disabled
      mode_d[MODE_EN_BIT] = sfr_wdata[MODE_EN_BIT] | mode_d[MODE_LOCK_BIT];
      if (!wd_on) begin
        mode_d[MODE_IDLE_BIT] = sfr_wdata[MODE_IDLE_BIT];
        mode_d[MODE_TB_LSB +: 3] = sfr_wdata[MODE_TB_LSB +: 3];
      end
    end
    mode_d = mode_d & MODE_WMASK;
  end

  // Run bit reads as written by software, not forced state
  always_comb begin
    case (sfr_addr)
      CTRL_ADDR:   rd_mux = ctrl_q;
      MODE_ADDR:   rd_mux = mode_q;
      CNT_LO_ADDR: rd_mux = cnt_lo_q;
      CNT_HI_ADDR: rd_mux = cnt_hi_q;
      M4_LO_ADDR:  rd_mux = m4_lo_q;
      M4_HI_ADDR:  rd_mux = m4_hi_q;
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      mode_q <= MODE_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_lo_q <= CNT_RESET;
      cnt_hi_q <= CNT_RESET;
    end else begin
      if (wr_lo) cnt_lo_q <= sfr_wdata;
      else if (count_en) cnt_lo_q <= cnt_lo_q + 8'h01;
      if (wr_hi) cnt_hi_q <= sfr_wdata;
      else if (lo_ovf) cnt_hi_q <= cnt_hi_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      m4_lo_q <= M4_LO_RESET;
      m4_hi_q <= 8'h00;
    end else begin
      if (wr_m4lo) m4_lo_q <= sfr_wdata;
      if (wr_m4hi) m4_hi_q <= cnt_hi_q + m4_lo_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
      wdrst_q  <= 1'b0;
      active_q <= 1'b1;
    end else begin
      if (sfr_rd) rdata_q <= rd_mux;
      irq_q    <= (ctrl_q[CTRL_OVF_BIT] & mode_q[MODE_IRQ_BIT]) |
                  (|(ctrl_q[3:0] & module_irq_en)) | (ctrl_q[CTRL_M4_BIT] & module4_irq_en);
      wdrst_q  <= force_rst | match_rst;
      active_q <= mode_d[MODE_EN_BIT] | mode_d[MODE_LOCK_BIT];
    end
  end

  assign sfr_rdata          = rdata_q;
  assign array_irq          = irq_q;
  assign watchdog_reset_req = wdrst_q;
  assign watchdog_active    = active_q;

  AST_LOCK_HOLDS: assert property (@(posedge mclk) disable iff (reset)
    mode_q[MODE_LOCK_BIT] |=> mode_q[MODE_EN_BIT] && mode_q[MODE_LOCK_BIT])
    else $error("lock released or enable cleared");
  AST_DISABLE: assert property (@(posedge mclk) disable iff (reset)
    wr_mode && !mode_q[MODE_LOCK_BIT] && !sfr_wdata[MODE_EN_BIT] && !sfr_wdata[MODE_LOCK_BIT]
    |=> !mode_q[MODE_EN_BIT] && !watchdog_active)
    else $error("enable zero write did not disable");
  AST_FROZEN: assert property (@(posedge mclk) disable iff (reset)
    wd_on |=> $stable(mode_q[MODE_TB_LSB +: 3]) && $stable(mode_q[MODE_IDLE_BIT]))
    else $error("timebase or idle changed while enabled");
  AST_UPDATE: assert property (@(posedge mclk) disable iff (reset)
    wr_m4hi |=> m4_hi_q == 8'($past(cnt_hi_q) + $past(m4_lo_q)))
    else $error("update byte not loaded with sum");
  AST_MATCH_RST: assert property (@(posedge mclk) disable iff (reset)
    wd_on && lo_ovf && cnt_hi_q == m4_hi_q |=> watchdog_reset_req)
    else $error("match did not request reset");
  AST_FORCE_RST: assert property (@(posedge mclk) disable iff (reset)
    wd_on && wr_ctrl && sfr_wdata[CTRL_M4_BIT] |=> watchdog_reset_req)
    else $error("forced reset missing");
  AST_NO_RST_OFF: assert property (@(posedge mclk) disable iff (reset)
    !wd_on && !(wr_ctrl || bit_wr) |=> !watchdog_reset_req)
    else $error("reset request while disabled");
  AST_OVF_SET: assert property (@(posedge mclk) disable iff (reset)
    ovf16 |=> ctrl_q[CTRL_OVF_BIT] && cnt_lo_q == 8'h00 && cnt_hi_q == 8'h00)
    else $error("wrap did not set overflow flag");
  AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (reset)
    ctrl_q[CTRL_OVF_BIT] && !wr_ctrl && !(bit_wr && bit_sel == 3'(CTRL_OVF_BIT)) |=> ctrl_q[CTRL_OVF_BIT])
    else $error("overflow flag cleared by hardware");
  AST_UNUSED_ZERO: assert property (@(posedge mclk) disable iff (reset)
    !ctrl_q[5] && !mode_q[4])
    else $error("unused bit set");
  AST_FORCED_RUN: assert property (@(posedge mclk) disable iff (reset)
    wd_on && tb.tick && !(mode_q[MODE_IDLE_BIT] && cpu_idle) && !wr_lo |=> cnt_lo_q == 8'($past(cnt_lo_q) + 8'h01))
    else $error("counter not forced on");
  AST_IDLE_HALT: assert property (@(posedge mclk) disable iff (reset)
    mode_q[MODE_IDLE_BIT] && cpu_idle && !wr_lo && !wr_hi |=> $stable(cnt_lo_q) && $stable(cnt_hi_q))
    else $error("counter moved during idle suspend");
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench for the counter array watchdog block
`timescale 1ns/1ps
module tb_top;
  import wdog_pkg::*;
  logic        mclk, reset, sfr_wr, sfr_rd, bit_wr, bit_val, cpu_idle, timer0_ovf, ext_in, module4_irq_en;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, v, w;
  logic [2:0]  bit_sel;
  logic [3:0]  module_match, module_irq_en;
  logic        array_irq, watchdog_reset_req, watchdog_active;
  logic [31:0] r;
  int          n_errors, n_compared, seed, n, e;

  wdog_ctrl u_dut (.mclk(mclk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val), .cpu_idle(cpu_idle),
    .timer0_ovf(timer0_ovf), .ext_in(ext_in), .module_match(module_match), .module_irq_en(module_irq_en),
    .module4_irq_en(module4_irq_en), .sfr_rdata(sfr_rdata), .array_irq(array_irq),
    .watchdog_reset_req(watchdog_reset_req), .watchdog_active(watchdog_active));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic conclude;
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ticks(1);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    ticks(1);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    ticks(1);
    sfr_rd = 1'b1;
    sfr_addr = a;
    ticks(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic bw(input logic [2:0] s, input logic b);
    ticks(1);
    bit_wr = 1'b1;
    bit_sel = s;
    bit_val = b;
    ticks(1);
    bit_wr = 1'b0;
  endtask

  task automatic rst;
    ticks(1);
    reset = 1'b1;
    ticks(4);
    reset = 1'b0;
  endtask

  // Bounded wait for the one-cycle reset request; n holds the cycles waited
  task automatic wait_req(input int lim);
    n = 0;
    while (watchdog_reset_req !== 1'b1) begin
      if (n == lim) begin
        n_errors++;
        $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
      end
      ticks(1);
      n++;
    end
  endtask

  // Cycles from a zero counter to the match on high byte hi: 256 timebase ticks per low-byte wrap
  function automatic int wd_cycles(input int hi, input int div);
    return 256 * (hi + 1) * div;
  endfunction

  // One-cycle pulses on the timer overflow input or on the external input
  task automatic pulses(input int k, input logic t0);
    repeat (k) begin
      timer0_ovf = t0;
      ext_in = ~t0;
      ticks(1);
      timer0_ovf = 1'b0;
      ext_in = 1'b0;
      ticks(1);
    end
  endtask

  initial begin
    {sfr_wr, sfr_rd, bit_wr, bit_val, cpu_idle, timer0_ovf, ext_in, module4_irq_en} = 8'h00;
    {sfr_addr, sfr_wdata, bit_sel, module_match, module_irq_en} = 27'h0;
    n_errors = 0;
    n_compared = 0;
    seed = 32'h98e2ba23;
    reset = 1'b1;
    ticks(4);
    reset = 1'b0;
    chk({7'h0, watchdog_active}, 8'h01);
    rd(MODE_ADDR, v);
    chk(v, 8'h40);
    rd(CTRL_ADDR, v);
    chk(v, 8'h00);
    rd(M4_LO_ADDR, v);
    chk(v, 8'h00);
    rd(8'h80, v);
    chk(v, 8'h00);
    // Default setup: 256 ticks of mclk/12 before the low byte wraps
    rst();
    e = wd_cycles(0, DIV12_CYCLES);
    wait_req(3300);
    chk({7'h0, n + 16 >= e && n <= e + 16}, 8'h01);
    wr(MODE_ADDR, 8'h00);
    ticks(2);
    chk({7'h0, watchdog_active}, 8'h00);
    wr(MODE_ADDR, 8'h98);
    rd(MODE_ADDR, v);
    chk(v, 8'h88);
    wr(MODE_ADDR, 8'hc8);
    wr(MODE_ADDR, 8'h42);
    rd(MODE_ADDR, v);
    chk(v, 8'hc8);
    wr(MODE_ADDR, 8'h60);
    wr(MODE_ADDR, 8'h00);
    rd(MODE_ADDR, v);
    chk(v, 8'he8);
    chk({7'h0, watchdog_active}, 8'h01);
    module4_irq_en = 1'b1;
    wr(CTRL_ADDR, 8'h10);
    wait_req(4);
    ticks(2);
    chk({7'h0, array_irq}, 8'h01);
    rst();
    rd(MODE_ADDR, v);
    chk(v, 8'h40);
    wr(MODE_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h2f);
    rd(CTRL_ADDR, v);
    chk(v, 8'h0f);
    bw(3'h2, 1'b0);
    rd(CTRL_ADDR, v);
    chk(v, 8'h0b);
    bw(3'h5, 1'b1);
    rd(CTRL_ADDR, v);
    chk(v, 8'h0b);
    wr(CTRL_ADDR, 8'h00);
    module_irq_en = 4'h1;
    ticks(1);
    module_match = 4'hf;
    ticks(1);
    module_match = 4'h0;
    ticks(2);
    chk({7'h0, array_irq}, 8'h01);
    ticks(20);
    rd(CTRL_ADDR, v);
    chk(v, 8'h0f);
    wr(CTRL_ADDR, 8'h00);
    ticks(2);
    chk({7'h0, array_irq}, 8'h00);
    // Idle suspend only matters while the counter would otherwise run
    wr(MODE_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'h40);
    cpu_idle = 1'b1;
    rd(CNT_LO_ADDR, v);
    ticks(60);
    rd(CNT_LO_ADDR, w);
    chk(w, v);
    cpu_idle = 1'b0;
    ticks(60);
    rd(CNT_LO_ADDR, w);
    chk({7'h0, w !== v}, 8'h01);
    wr(CTRL_ADDR, 8'h00);
    rd(CNT_LO_ADDR, v);
    ticks(60);
    rd(CNT_LO_ADDR, w);
    chk(w, v);
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      if (i == 0) r[15:0] = 16'h01ff;
      wr(CNT_HI_ADDR, r[7:0]);
      wr(M4_LO_ADDR, r[15:8]);
      wr(M4_HI_ADDR, r[23:16]);
      rd(M4_HI_ADDR, v);
      chk(v, r[7:0] + r[15:8]);
    end
    wr(MODE_ADDR, 8'h08);
    wr(CNT_HI_ADDR, 8'hff);
    wr(CNT_LO_ADDR, 8'hf0);
    wr(CTRL_ADDR, 8'h40);
    ticks(30);
    rd(CTRL_ADDR, v);
    chk(v, 8'hc0);
    chk({7'h0, array_irq}, 8'h00);
    wr(MODE_ADDR, 8'h09);
    ticks(2);
    chk({7'h0, array_irq}, 8'h01);
    ticks(20);
    rd(CTRL_ADDR, v);
    chk(v, 8'hc0);
    wr(CTRL_ADDR, 8'h40);
    rd(CTRL_ADDR, v);
    chk(v, 8'h40);
    // Software setup order: disable, timebase div4, offset one, idle off, enable, update
    rst();
    wr(MODE_ADDR, 8'h00);
    wr(MODE_ADDR, 8'h02);
    wr(M4_LO_ADDR, 8'h01);
    wr(MODE_ADDR, 8'h02);
    wr(MODE_ADDR, 8'h42);
    wr(M4_HI_ADDR, 8'h5a);
    rd(M4_HI_ADDR, v);
    chk(v, 8'h01);
    e = wd_cycles(1, DIV4_CYCLES);
    wait_req(2300);
    chk({7'h0, n + 16 >= e && n <= e + 16}, 8'h01);
    // Edge and timer timebases; the counter only moves on their ticks
    wr(MODE_ADDR, 8'h00);
    wr(MODE_ADDR, 8'h06);
    wr(CTRL_ADDR, 8'h40);
    rd(CNT_LO_ADDR, v);
    pulses(5, 1'b0);
    rd(CNT_LO_ADDR, w);
    chk(w, v + 8'h05);
    wr(MODE_ADDR, 8'h0a);
    rd(CNT_LO_ADDR, v);
    pulses(2 * DIV8_CYCLES, 1'b0);
    rd(CNT_LO_ADDR, w);
    chk(w, v + 8'h02);
    wr(MODE_ADDR, 8'h04);
    rd(CNT_LO_ADDR, v);
    pulses(3, 1'b1);
    rd(CNT_LO_ADDR, w);
    chk(w, v + 8'h03);
    conclude();
  end
endmodule
